/* File: angle_pkg.sv */
// Constants, types and register layout for the angle post-processing block
package angle_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] CMD_RESULT_ADDR = 16'h0000;
    localparam logic [15:0] EXT_READ_ADDR = 16'h000E;
    localparam logic [15:0] EXT_READ_LAST = 16'h0011;
    localparam logic [15:0] SELF_TEST_ID_ADDR = 16'hFFFC;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 40;
    localparam int SAMPLE_US = 32;
    localparam int SAMPLE_CYC = SAMPLE_US * 1000 / CLK_NS;
    localparam int HALL_TEST_MS = 36;
    localparam int HALL_TEST_CYC = HALL_TEST_MS * 1000000 / CLK_NS;
    localparam int MEM_SHORT_US = 100;
    localparam int MEM_SHORT_CYC = MEM_SHORT_US * 1000 / CLK_NS;
    localparam int MEM_LONG_FACTOR = 8;
    localparam int TIMEOUT_FACTOR = 2;

    // ------------------------------------------------------------
    // Field steps and bit positions
    // ------------------------------------------------------------
    localparam logic [15:0] STRONG_STEP_G = 16'h0028;
    localparam logic [15:0] WEAK_STEP_G = 16'h0014;
    localparam logic [15:0] HALF_TURN = 16'h8000;
    localparam logic [15:0] ROUND_HALF = 16'h0008;
    localparam logic [15:0] FULL_CODE = 16'hFFFF;
    localparam int TBIT_HALL = 0;
    localparam int TBIT_MEM = 1;
    localparam int TBIT_ROM = 2;

    // Self-test command codes
    typedef enum logic [1:0] {
        CMD_NONE = 2'b00,
        CMD_HALL = 2'b01,
        CMD_MEM = 2'b10,
        CMD_ROM = 2'b11
    } test_cmd_t;

    typedef enum logic [1:0] {
        T_IDLE = 2'b00,
        T_HALL = 2'b01,
        T_MEM = 2'b10,
        T_ROM = 2'b11
    } test_state_t;

    // Processing configuration
    typedef struct packed {
        logic [2:0] averaging_select;
        logic input_direction_bit;
        logic [15:0] gain_shift;
        logic short_stroke;
        logic [15:0] min_angle;
        logic [15:0] max_angle;
        logic [15:0] stroke_gain;
        logic harmonic_lin_enable;
        logic segmented_lin_enable;
        logic [15:0] lin_offset;
        logic [15:0] lin_coeffs;
        logic [15:0] zero_offset;
        logic output_polarity_bit;
        logic [15:0] upper_limit;
        logic [15:0] lower_limit;
        logic die_adjust;
        logic [4:0] field_strong_limit;
        logic [4:0] field_weak_limit;
        logic mem_long_mode;
        logic mem_halt_on_error;
    } proc_cfg_t;

    // Diagnostic event inputs
    typedef struct packed {
        logic supply_over;
        logic prog_pulse;
        logic supply_under;
        logic temp_out;
        logic proc_halt;
        logic nv_single;
        logic nv_multi;
        logic ram_single;
        logic ram_multi;
        logic power_lost;
    } diag_evt_t;

    // Sticky flags
    typedef struct packed {
        logic angle_high_flag;
        logic angle_low_flag;
        logic self_check_fail_flag;
        logic field_high_flag;
        logic field_low_flag;
        logic undervoltage_flag;
        logic supply_high_flag;
        logic temp_range_flag;
        logic watchdog_timeout_flag;
        logic watchdog_count_flag;
        logic eeprom_corrected_flag;
        logic eeprom_uncorrectable_flag;
        logic sram_corrected_flag;
        logic sram_uncorrectable_flag;
        logic angle_timeout_flag;
        logic power_loss_flag;
        logic reset_occurred_flag;
    } diag_flags_t;

endpackage : angle_pkg

/* File: angle_postproc_and_diag.sv */
// Angle post-processing pipeline with diagnostic flags and self-tests
`timescale 1ns/10ps
module angle_postproc_and_diag
    import angle_pkg::*;
#(
    parameter int HALL_CYCLES = HALL_TEST_CYC,
    parameter int MEM_CYCLES = MEM_SHORT_CYC,
    parameter int ROM_CYCLES = 64
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic sample_valid,
    input wire logic [15:0] raw_angle,
    input wire logic [15:0] field_gauss,
    input wire proc_cfg_t cfg,
    input wire diag_evt_t evt_pin,
    input wire logic test_start,
    input wire test_cmd_t test_cmd,
    input wire logic hall_fail,
    input wire logic [15:0] hall_result,
    input wire logic [31:0] hall_elements,
    input wire logic mem_fail,
    input wire logic rom_fail,
    input wire logic flags_clear,
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data,
    output logic [31:0] rd_wide,
    output logic [11:0] angle_out,
    output logic angle_valid,
    output diag_flags_t flags,
    output logic test_busy
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (HALL_CYCLES < 1 || MEM_CYCLES < 1 || ROM_CYCLES < 1) begin : g_chk
        $error("Self-test durations must be at least one cycle");
    end

    // Rounds 16-bit angle to 12 bits, wrapping at full turn
    function automatic logic [11:0] round12(input logic [15:0] a);
        logic [15:0] s;
        s = a + ROUND_HALF;
        return s[15:4];
    endfunction : round12

    // Clamp a value into [lo, hi]
    function automatic logic [15:0] clamp16(input logic [15:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v > hi) begin
            r = hi;
        end else if (v < lo) begin
            r = lo;
        end
        return r;
    endfunction : clamp16

    // ------------------------------------------------------------
    // Synchronise pin-level diagnostic events
    // ------------------------------------------------------------
    diag_evt_t evt_s1;
    diag_evt_t evt;
    always_ff @(posedge sys_clk) begin
        evt_s1 <= srst ? diag_evt_t'('0) : evt_pin;
        evt <= srst ? diag_evt_t'('0) : evt_s1;
    end

    // ------------------------------------------------------------
    // Self-test sequencer
    // ------------------------------------------------------------
    test_state_t state;
    test_state_t next_state;
    logic [31:0] tcnt;
    logic [2:0] fail_id;
    logic [15:0] cmd_result;
    logic [31:0] ext_read;
    logic [31:0] mem_len;
    logic tdone;
    logic tfail;
    logic init_mem;

    // Short mode forced only in the first cycle of the power-up run, while init_mem is set
    assign mem_len = (cfg.mem_long_mode && !init_mem)
                     ? 32'(MEM_CYCLES * MEM_LONG_FACTOR) : 32'(MEM_CYCLES);
    // Halt on error ends memory test at first failure
    assign tdone = (state == T_HALL && tcnt == 32'(HALL_CYCLES - 1))
                || (state == T_MEM && (tcnt == mem_len - 32'd1
                    || (cfg.mem_halt_on_error && mem_fail)))
                || (state == T_ROM && tcnt == 32'(ROM_CYCLES - 1));
    assign tfail = (state == T_HALL && hall_fail)
                || (state == T_MEM && mem_fail)
                || (state == T_ROM && rom_fail);

    // Next state of the self-test sequencer
    always_comb begin
        next_state = state;
        case (state)
            T_IDLE: begin
                if (init_mem) begin
                    next_state = T_MEM;
                end else if (test_start) begin
                    next_state = test_state_t'(test_cmd);
                end
            end
            T_HALL, T_MEM, T_ROM: begin
                if (tdone) begin
                    next_state = T_IDLE;
                end
            end
            default: next_state = T_IDLE;
        endcase
    end

    // Sequencer registers; failing test identity kept per test
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= T_IDLE;
            tcnt <= 32'h0000_0000;
            fail_id <= 3'b000;
            init_mem <= 1'b1;
            cmd_result <= 16'h0000;
            ext_read <= 32'h0000_0000;
        end else begin
            state <= next_state;
            tcnt <= (state != next_state || tdone) ? 32'h0000_0000
                                                   : tcnt + 32'd1;
            if (state == T_MEM) begin
                init_mem <= 1'b0;
            end
            if (tfail && state == T_HALL) begin
                fail_id[TBIT_HALL] <= 1'b1;
            end
            if (tfail && state == T_MEM) begin
                fail_id[TBIT_MEM] <= 1'b1;
            end
            if (tfail && state == T_ROM) begin
                fail_id[TBIT_ROM] <= 1'b1;
            end
            if (state == T_HALL && tdone) begin
                cmd_result <= hall_result;
                ext_read <= hall_elements;
            end
        end
    end

    // ------------------------------------------------------------
    // Averaging; no samples accepted during hall test
    // ------------------------------------------------------------
    logic [22:0] acc;
    logic [7:0] nsamp;
    logic [7:0] avg_target;
    logic avg_done;
    logic [15:0] dir_angle;
    logic [15:0] avg_angle;
    logic take;

    assign take = sample_valid && state != T_HALL;
    // Direction bit flips rotation sense into the pipeline
    assign dir_angle = cfg.input_direction_bit ? 16'(-raw_angle) : raw_angle;
    assign avg_target = 8'(1 << cfg.averaging_select);
    assign avg_done = take && (nsamp + 8'd1 == avg_target);
    assign avg_angle = 16'((acc + 23'(dir_angle)) >> cfg.averaging_select);

    // Accumulates 2^n samples before one pipeline entry
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            acc <= 23'h00_0000;
            nsamp <= 8'h00;
        end else if (take) begin
            acc <= avg_done ? 23'h00_0000 : acc + 23'(dir_angle);
            nsamp <= avg_done ? 8'h00 : nsamp + 8'd1;
        end
    end

    // ------------------------------------------------------------
    // Post-processing stages at 16 bits, with 32-bit products and a 12-bit rounded result
    // ------------------------------------------------------------
    logic [15:0] s_off;
    logic [31:0] s_prod;
    logic [15:0] s_scale;
    logic [15:0] s_lin_in;
    logic [31:0] s_corr;
    logic [15:0] s_lin;
    logic [15:0] s_zero;
    logic [15:0] s_pol;
    logic [15:0] s_clamp;
    logic [11:0] s_round;
    logic over_max;
    logic under_min;

    // Zeroing shift ahead of gain
    assign s_off = avg_angle - cfg.gain_shift;
    // Bound check on angle before scaling
    assign over_max = cfg.short_stroke && s_off > cfg.max_angle;
    assign under_min = cfg.short_stroke && s_off < cfg.min_angle;
    // Gain is 8.8 fixed point, saturating at full code
    assign s_prod = (32'(s_off - cfg.min_angle) * 32'(cfg.stroke_gain)) >> 8;
    assign s_scale = !cfg.short_stroke ? s_off
                   : (s_prod > 32'(FULL_CODE)) ? FULL_CODE : s_prod[15:0];
    // Linearization input made continuous over full turn
    assign s_lin_in = s_scale - cfg.lin_offset;
    // Coefficient is a signed scale of a first-harmonic-like term
    // Operands widened first so the full product survives the shift
    assign s_corr = 32'((34'($signed({1'b0, s_lin_in[14:0]}))
                        * 34'($signed(cfg.lin_coeffs))) >>> 15);
    assign s_lin = (cfg.harmonic_lin_enable || cfg.segmented_lin_enable)
                   ? s_lin_in + s_corr[15:0] : s_lin_in;
                   // Same correction path for segments
    assign s_zero = s_lin - cfg.zero_offset;
    assign s_pol = cfg.output_polarity_bit ? 16'(-s_zero) : s_zero;
    assign s_clamp = cfg.short_stroke
                     ? clamp16(s_pol, cfg.lower_limit, cfg.upper_limit)
                     : s_pol;
    assign s_round = round12(cfg.die_adjust ? s_clamp + HALF_TURN : s_clamp);

    // Result register, one per refresh, order fixed above
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            angle_out <= 12'h000;
            angle_valid <= 1'b0;
        end else begin
            angle_valid <= avg_done;
            if (avg_done) begin
                angle_out <= s_round;
            end
        end
    end

    // ------------------------------------------------------------
    // Angle timeout watchdog
    // ------------------------------------------------------------
    logic [31:0] since;
    logic [31:0] tmo_limit;
    logic timeout;
    // Allow twice the refresh period before calling it late
    assign tmo_limit = 32'(SAMPLE_CYC * TIMEOUT_FACTOR) << cfg.averaging_select;
    assign timeout = since >= tmo_limit && state != T_HALL;

    always_ff @(posedge sys_clk) begin
        if (srst || avg_done || state == T_HALL) begin
            since <= 32'h0000_0000;
        end else if (!timeout) begin
            since <= since + 32'd1;
        end
    end

    // ------------------------------------------------------------
    // Sticky flags; a set wins over a clear in the same cycle
    // ------------------------------------------------------------
    diag_flags_t set_v;
    diag_flags_t next_flags;
    always_comb begin
        set_v = '0;
        set_v.angle_high_flag = avg_done && over_max;
        set_v.angle_low_flag = avg_done && under_min;
        set_v.self_check_fail_flag = tfail;
        set_v.field_high_flag = field_gauss >
            16'(cfg.field_strong_limit * STRONG_STEP_G);
        set_v.field_low_flag = field_gauss <
            16'(cfg.field_weak_limit * WEAK_STEP_G);
        set_v.undervoltage_flag = evt.supply_under;
        set_v.supply_high_flag = evt.supply_over || evt.prog_pulse;
        set_v.temp_range_flag = evt.temp_out;
        set_v.watchdog_timeout_flag = evt.proc_halt;
        set_v.watchdog_count_flag = evt.proc_halt;
        set_v.eeprom_corrected_flag = evt.nv_single;
        set_v.eeprom_uncorrectable_flag = evt.nv_multi;
        set_v.sram_corrected_flag = evt.ram_single;
        set_v.sram_uncorrectable_flag = evt.ram_multi;
        set_v.angle_timeout_flag = timeout;
        set_v.power_loss_flag = evt.power_lost;
        set_v.reset_occurred_flag = evt.power_lost;
        next_flags = set_v | (flags_clear ? diag_flags_t'('0) : flags);
    end

    // Reset itself counts as a processor reset event
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flags <= '0;
            flags.power_loss_flag <= 1'b1;
            flags.reset_occurred_flag <= 1'b1;
        end else begin
            flags <= next_flags;
        end
    end

    // ------------------------------------------------------------
    // Read port: result field, extended data, failing-test id
    // ------------------------------------------------------------
    logic [15:0] next_rd;
    assign next_rd = (rd_addr == CMD_RESULT_ADDR) ? cmd_result
                   : (rd_addr == SELF_TEST_ID_ADDR) ? {13'h0000, fail_id}
                   : 16'h0000;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_data <= 16'h0000;
            rd_wide <= 32'h0000_0000;
            test_busy <= 1'b0;
        end else begin
            rd_data <= next_rd;
            rd_wide <= (rd_addr >= EXT_READ_ADDR && rd_addr <= EXT_READ_LAST)
                       ? ext_read : 32'h0000_0000;
            test_busy <= next_state != T_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence hall_run;
        state == T_HALL;
    endsequence

    chk_hall_no_angle: assert property (@(posedge sys_clk) disable iff (srst)
        hall_run |=> !angle_valid)
        else $error("Angle produced during hall self-test");
    chk_watchdog_pair: assert property (@(posedge sys_clk) disable iff (srst)
        evt.proc_halt |=> flags.watchdog_timeout_flag && flags.watchdog_count_flag)
        else $error("Halt did not set both watchdog flags");
    chk_fail_sticky: assert property (@(posedge sys_clk) disable iff (srst)
        tfail |=> flags.self_check_fail_flag)
        else $error("Self-test failure not flagged");
    chk_prog_pulse: assert property (@(posedge sys_clk) disable iff (srst)
        evt.prog_pulse |=> flags.supply_high_flag)
        else $error("Programming pulse did not set supply flag");
    chk_clamp_range: assert property (@(posedge sys_clk) disable iff (srst)
        avg_done && cfg.short_stroke && cfg.lower_limit <= cfg.upper_limit
        |-> s_clamp <= cfg.upper_limit && s_clamp >= cfg.lower_limit)
        else $error("Clamped angle outside limits");
    chk_round_out: assert property (@(posedge sys_clk) disable iff (srst)
        avg_done && !cfg.die_adjust |=> angle_out == round12($past(s_clamp)))
        else $error("Output differs from rounded result");
    chk_set_wins: assert property (@(posedge sys_clk) disable iff (srst)
        flags_clear && evt.nv_multi |=> flags.eeprom_uncorrectable_flag)
        else $error("Event lost under clear");
    chk_valid_pulse: assert property (@(posedge sys_clk) disable iff (srst)
        angle_valid |=> !angle_valid || $past(avg_done))
        else $error("Valid without refresh");

endmodule : angle_postproc_and_diag

/* File: host_model.sv */
// Host microcontroller model: register reads and self-test starts
`timescale 1ns/10ps
module host_model
    import angle_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [15:0] rd_data,
    input wire logic [31:0] rd_wide,
    output logic [15:0] rd_addr,
    output logic test_start,
    output test_cmd_t test_cmd
);
    // Idle host: address zero, no command
    initial begin
        rd_addr = 16'h0000;
        test_start = 1'b0;
        test_cmd = CMD_NONE;
    end

    // Address held two edges so the registered answer has landed
    task automatic read_reg(input logic [15:0] a, output logic [15:0] d,
                            output logic [31:0] w);
        @(posedge sys_clk);
        rd_addr <= a;
        repeat (2) @(posedge sys_clk);
        #1;
        d = rd_data;
        w = rd_wide;
    endtask : read_reg

    // One-cycle start strobe; caller waits for idle first
    task automatic start_test(input test_cmd_t c);
        @(posedge sys_clk);
        test_cmd <= c;
        test_start <= 1'b1;
        @(posedge sys_clk);
        test_start <= 1'b0;
    endtask : start_test
endmodule : host_model

/* File: tb_top.sv */
// Self-checking bench for the angle post-processing block
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
    import angle_pkg::*;
    logic sys_clk = 0, srst = 1, sample_valid = 0, flags_clear = 0;
    logic hall_fail = 0, mem_fail = 0, rom_fail = 0;
    logic [15:0] raw_angle = 0, field_gauss = 16'h012C, hall_result = 0;
    logic [31:0] hall_elements = 0, rd_wide, w;
    logic [15:0] rd_addr, rd_data, d, r;
    logic [11:0] angle_out;
    logic angle_valid, test_busy, test_start;
    test_cmd_t test_cmd;
    proc_cfg_t cfg = '{field_strong_limit: 5'd31, default: 0};
    diag_evt_t evt_pin = '0;
    diag_flags_t flags, got;
    int mismatches = 0, comparisons = 0, nval = 0, seed;

    // --------------------------------------------------------
    // Design, host and clock
    // --------------------------------------------------------
    angle_postproc_and_diag #(.HALL_CYCLES(20), .MEM_CYCLES(10),
        .ROM_CYCLES(8)) u_angle_postproc_and_diag (.sys_clk(sys_clk),
        .srst(srst), .sample_valid(sample_valid), .raw_angle(raw_angle),
        .field_gauss(field_gauss), .cfg(cfg), .evt_pin(evt_pin),
        .test_start(test_start), .test_cmd(test_cmd),
        .hall_fail(hall_fail), .hall_result(hall_result),
        .hall_elements(hall_elements), .mem_fail(mem_fail),
        .rom_fail(rom_fail), .flags_clear(flags_clear),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_wide(rd_wide),
        .angle_out(angle_out), .angle_valid(angle_valid),
        .flags(flags), .test_busy(test_busy));
    host_model u_host_model (.sys_clk(sys_clk), .rd_data(rd_data),
        .rd_wide(rd_wide), .rd_addr(rd_addr), .test_start(test_start),
        .test_cmd(test_cmd));
    always #20 sys_clk = ~sys_clk;
    // Counts refresh pulses; feed clears it at the start of each call
    always @(posedge sys_clk) if (angle_valid === 1'b1) nval <= nval + 1;

    // --------------------------------------------------------
    // Expectations and helpers
    // --------------------------------------------------------
    // Full-path reference, no linearization, short stroke or output polarity
    function automatic logic [11:0] exp_angle(input logic [15:0] a);
        a = cfg.input_direction_bit ? 16'h0000 - a : a;
        a = a - cfg.gain_shift - cfg.zero_offset;
        if (cfg.die_adjust) a = a + HALF_TURN;
        a = a + ROUND_HALF;
        return a[15:4];
    endfunction : exp_angle
    // Flags raised by each event pin, MSB first
    function automatic diag_flags_t exp_evt(input int i);
        diag_flags_t f = '0;
        case (i)
            0, 1: f.supply_high_flag = 1'b1;
            2: f.undervoltage_flag = 1'b1;
            3: f.temp_range_flag = 1'b1;
            4: {f.watchdog_timeout_flag, f.watchdog_count_flag} = 2'b11;
            5: f.eeprom_corrected_flag = 1'b1;
            6: f.eeprom_uncorrectable_flag = 1'b1;
            7: f.sram_corrected_flag = 1'b1;
            8: f.sram_uncorrectable_flag = 1'b1;
            default: {f.power_loss_flag, f.reset_occurred_flag} = 2'b11;
        endcase
        return f;
    endfunction : exp_evt
    // Back-to-back samples, reps groups of the averaging size
    task automatic feed(input logic [15:0] v, input int reps);
        int n;
        @(posedge sys_clk);
        n = reps << cfg.averaging_select;
        nval = 0;
        repeat (n) begin
            sample_valid <= 1'b1;
            raw_angle <= v;
            @(posedge sys_clk);
        end
        sample_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask : feed
    task automatic clr();
        @(posedge sys_clk) flags_clear <= 1'b1;
        @(posedge sys_clk) flags_clear <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : clr
    // Clear happens while the field stays put, so set must win
    task automatic fld(input logic [15:0] g, input logic [1:0] e);
        @(posedge sys_clk) field_gauss <= g;
        repeat (4) @(posedge sys_clk);
        clr();
        `CHK({flags.field_high_flag, flags.field_low_flag}, e)
    endtask : fld
    task automatic wait_idle();
        int n = 0;
        while (test_busy !== 1'b0 && n < 200) begin
            @(posedge sys_clk);
            #1 n++;
        end
    endtask : wait_idle
    task automatic wrap_up();
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Hang guard, far beyond the few thousand cycles needed
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        wrap_up();
    end

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        seed = $urandom(33064);
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        #1 `CHK(flags, exp_evt(9))
        `CHK(test_busy, 1'b1)
        wait_idle();
        for (int i = 0; i < 16; i++) begin
            r = (i == 0) ? 16'hFFF8 : 16'($urandom);
            @(posedge sys_clk);
            cfg.averaging_select <= 3'(i);
            cfg.input_direction_bit <= (i == 0) ? 1'b0 : 1'($urandom);
            cfg.gain_shift <= (i == 0) ? 16'h0000 : 16'($urandom);
            cfg.zero_offset <= (i == 0) ? 16'h0000 : 16'($urandom);
            cfg.die_adjust <= (i == 0) ? 1'b0 : 1'($urandom);
            feed(r, 1);
            `CHK(nval, 1)
            `CHK(angle_out, exp_angle(r))
        end
        for (int i = 0; i < 10; i++) begin
            clr();
            @(posedge sys_clk) evt_pin <= diag_evt_t'(10'h200 >> i);
            repeat (2) @(posedge sys_clk);
            evt_pin <= '0;
            repeat (4) @(posedge sys_clk);
            #1 got = flags;
            got.angle_timeout_flag = 1'b0;
            `CHK(got, exp_evt(i))
        end
        @(posedge sys_clk) cfg.field_weak_limit <= 5'd10;
        fld(16'd200, 2'b00);
        fld(16'd199, 2'b01);
        fld(16'd1240, 2'b00);
        fld(16'd1241, 2'b10);
        fld(16'd300, 2'b00);
        // Coefficient of one half adds half the offset angle back
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            cfg <= '{harmonic_lin_enable: k == 0, segmented_lin_enable: k == 1,
                lin_offset: 16'h0100, lin_coeffs: 16'h4000,
                field_strong_limit: 5'd31,
                field_weak_limit: 5'd10, default: 0};
            feed(16'h2345, 1);
            `CHK(angle_out, (k < 2) ? 12'h336 : 12'h224)
        end
        @(posedge sys_clk);
        cfg <= '{short_stroke: 1'b1, min_angle: 16'h1000,
            max_angle: 16'h2000, stroke_gain: 16'h0100,
            upper_limit: 16'h1800, field_strong_limit: 5'd31,
            field_weak_limit: 5'd10, default: 0};
        clr();
        feed(16'h1800, 1);
        `CHK(angle_out, 12'h080)
        `CHK({flags.angle_high_flag, flags.angle_low_flag}, 2'b00)
        feed(16'h3000, 1);
        `CHK(angle_out, 12'h180)
        `CHK(flags.angle_high_flag, 1'b1)
        feed(16'h0800, 1);
        `CHK(flags.angle_low_flag, 1'b1)
        clr();
        repeat (100) @(posedge sys_clk);
        #1 `CHK(flags.angle_timeout_flag, 1'b0)
        repeat (1600) @(posedge sys_clk);
        #1 `CHK(flags.angle_timeout_flag, 1'b1)
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            {rom_fail, mem_fail, hall_fail} <= 3'(1 << k);
            hall_result <= 16'($urandom);
            hall_elements <= $urandom;
            clr();
            u_host_model.start_test(test_cmd_t'(k + 1));
            feed(16'h0400, 10);
            if (k == 0) `CHK(nval, 0)
            wait_idle();
            u_host_model.read_reg(SELF_TEST_ID_ADDR, d, w);
            `CHK(d[k], 1'b1)
            `CHK(flags.self_check_fail_flag, 1'b1)
            if (k == 0) begin
                u_host_model.read_reg(CMD_RESULT_ADDR, d, w);
                `CHK(d, hall_result)
                u_host_model.read_reg(EXT_READ_LAST, d, w);
                `CHK(w, hall_elements)
            end
        end
        wrap_up();
    end
endmodule : tb_top
